// file: src/diag_serial.v
// two-wire management slave serving identification and diagnostic spaces
`timescale 1ns/10ps
`default_nettype none
`include "diag_serial_map.vh"

// Summary of operation
// - drive receive_signal_lost pin high when optical input power is too low.
// - report receive_signal_lost as bit 1 of diagnostic byte 110.
// - serve identification bytes 0..255 at device address 0xA0.
// - serve diagnostic bytes 0..255 at device address 0xA2 when enabled.
// - identification reads follow the usual serial memory read protocol.
// - present calibrated voltage, temperature, tx power, bias, rx power readings.
// - host can turn transmitter off and read fault and loss status.
// - software off bit 6 ORed with hardware off pin disables transmitter.
// - report hardware transmitter-off pin state as bit 7 of byte 110.
// - report transmitter fault as bit 2 of byte 110 and on pin.
// - laser fault latches until off-input toggles; low supply fault does not latch.
module diag_serial #(
  parameter DIAG_PRESENT = 1
) (
  // clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // two-wire serial pins
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_oe_n,
  // optical front end status and control
  input  wire        tx_off_pin,
  input  wire        laser_fault,
  input  wire        supply_low,
  input  wire        optical_power_low,
  output reg         tx_disable,
  output reg         tx_fault,
  output reg         receive_signal_lost,
  // calibrated monitor readings
  input  wire [15:0] temp_value,
  input  wire [15:0] vcc_value,
  input  wire [15:0] bias_value,
  input  wire [15:0] txpwr_value,
  input  wire [15:0] rxpwr_value,
  // identification memory write port
  input  wire        id_wr,
  input  wire [7:0]  id_wr_addr,
  input  wire [7:0]  id_wr_data
);

  localparam S_IDLE = 3'd0;
  localparam S_DEVA = 3'd1;
  localparam S_ACK  = 3'd2;
  localparam S_WADR = 3'd3;
  localparam S_WDAT = 3'd4;
  localparam S_READ = 3'd5;
  localparam S_RACK = 3'd6;

  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [2:0] hw_s;
  reg [1:0] lf_s;
  reg [1:0] sl_s;
  reg [1:0] op_s;
  reg [2:0] state;
  reg [2:0] after_ack;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg       sel_diag;
  reg       sw_txoff;
  reg       fault_latch;
  reg [7:0] id_mem [0:255];
  reg [7:0] rd_byte;

  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c = scl & scl_s[2] & ~sda & sda_s[2];
  wire stop_c  = scl & scl_s[2] & sda & ~sda_s[2];
  wire hw_off  = hw_s[1];

  // fetch a byte from the space addressed
  function [7:0] diag_byte;
    input [7:0] a;
    begin
      if (a == `OFS_CTRL_STATUS)
        diag_byte = {hw_off, sw_txoff, 3'h0, tx_fault, receive_signal_lost, 1'b0};
      else if (a == `OFS_TEMP_MSB)     diag_byte = temp_value[15:8];
      else if (a == `OFS_TEMP_MSB+1)   diag_byte = temp_value[7:0];
      else if (a == `OFS_VCC_MSB)      diag_byte = vcc_value[15:8];
      else if (a == `OFS_VCC_MSB+1)    diag_byte = vcc_value[7:0];
      else if (a == `OFS_BIAS_MSB)     diag_byte = bias_value[15:8];
      else if (a == `OFS_BIAS_MSB+1)   diag_byte = bias_value[7:0];
      else if (a == `OFS_TXPWR_MSB)    diag_byte = txpwr_value[15:8];
      else if (a == `OFS_TXPWR_MSB+1)  diag_byte = txpwr_value[7:0];
      else if (a == `OFS_RXPWR_MSB)    diag_byte = rxpwr_value[15:8];
      else if (a == `OFS_RXPWR_MSB+1)  diag_byte = rxpwr_value[7:0];
      else                             diag_byte = 8'h00;
    end
  endfunction

  always @* begin
    if (sel_diag)
      rd_byte = diag_byte(ptr);
    else
      rd_byte = id_mem[ptr];
  end

  always @(posedge mclk) begin
    scl_s <= {scl_s[1:0], scl_in};
    sda_s <= {sda_s[1:0], sda_in};
    hw_s  <= {hw_s[1:0], tx_off_pin};
    lf_s  <= {lf_s[0], laser_fault};
    sl_s  <= {sl_s[0], supply_low};
    op_s  <= {op_s[0], optical_power_low};
    if (id_wr)
      id_mem[id_wr_addr] <= id_wr_data;
  end

  // transmitter control and status; fault clear only on an off-pin edge
  always @(posedge mclk) begin
    if (!resetn) begin
      fault_latch         <= 1'b0;
      tx_disable          <= 1'b1;
      tx_fault            <= 1'b0;
      receive_signal_lost <= 1'b0;
    end else begin
      if (lf_s[1])
        fault_latch <= 1'b1;
      else if (hw_s[1] != hw_s[2])
        fault_latch <= 1'b0;
      tx_fault            <= fault_latch | lf_s[1] | sl_s[1];
      tx_disable          <= hw_off | sw_txoff | fault_latch | lf_s[1] | sl_s[1];
      receive_signal_lost <= op_s[1];
    end
  end

  // serial slave engine; open-drain data low while acking or sending a zero
  always @(posedge mclk) begin
    if (!resetn) begin
      state     <= S_IDLE;
      after_ack <= S_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      sel_diag  <= 1'b0;
      sw_txoff  <= `RST_SW_TXOFF;
      sda_oe_n  <= 1'b1;
    end else if (stop_c) begin
      state    <= S_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start_c) begin
      state    <= S_DEVA;
      bit_cnt  <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        S_DEVA, S_WADR, S_WDAT: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            state   <= S_ACK;
            if (state == S_DEVA) begin
              if (shreg[7:1] == `DEV_ADDR_ID ||
                  (DIAG_PRESENT != 0 && shreg[7:1] == `DEV_ADDR_DIAG)) begin
                sda_oe_n  <= 1'b0;
                sel_diag  <= (shreg[7:1] == `DEV_ADDR_DIAG);
                after_ack <= shreg[0] ? S_READ : S_WADR;
              end else begin
                state <= S_IDLE;
              end
            end else begin
              sda_oe_n  <= 1'b0;
              after_ack <= S_WDAT;
              if (state == S_WADR) begin
                ptr <= shreg;
              end else begin
                if (sel_diag && ptr == `OFS_CTRL_STATUS)
                  sw_txoff <= shreg[`BIT_SW_TXOFF];
                ptr <= ptr + 8'h01;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state <= after_ack;
            if (after_ack == S_READ) begin
              shreg    <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              bit_cnt  <= 4'h1;
              ptr      <= ptr + 8'h01;
            end else begin
              sda_oe_n <= 1'b1;
            end
          end
        end
        S_READ: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              state    <= S_RACK;
            end else begin
              sda_oe_n <= shreg[7];
              shreg    <= {shreg[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          // master nack ends the read; ack continues sequentially
          if (scl_rise) begin
            if (sda) begin
              state <= S_IDLE;
            end else begin
              state     <= S_ACK;
              after_ack <= S_READ;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // diag_serial
`default_nettype wire

// file: src/diag_serial_map.vh
// constants for the transceiver management serial slave
`ifndef DIAG_SERIAL_MAP_VH
`define DIAG_SERIAL_MAP_VH
`define DEV_ADDR_ID        7'h50
`define DEV_ADDR_DIAG      7'h51
`define OFS_CTRL_STATUS    8'h6E
`define BIT_HW_TXOFF       7
`define BIT_SW_TXOFF       6
`define BIT_TX_FAULT       2
`define BIT_SIGNAL_LOST    1
`define RST_SW_TXOFF       1'b0
`define OFS_TEMP_MSB       8'h60
`define OFS_VCC_MSB        8'h62
`define OFS_BIAS_MSB       8'h64
`define OFS_TXPWR_MSB      8'h66
`define OFS_RXPWR_MSB      8'h68
`endif

// file: tb/serial_host.sv
// two-wire host model driving the serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  // clock
  input  wire logic mclk,
  // serial pins
  input  wire logic sda_oe_n,
  output var  logic scl,
  output wire logic sda
);
  logic drv = 1'b1;
  // released line reads high through the pull-up
  assign sda = drv & sda_oe_n;
  initial scl = 1'b1;
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0; w(4); drv = b; w(4); scl = 1'b1; w(8); r = sda;
  endtask
  task automatic start();
    scl = 1'b0; w(4); drv = 1'b1; w(4); scl = 1'b1; w(8); drv = 1'b0; w(8);
  endtask
  task automatic stop();
    scl = 1'b0; w(4); drv = 1'b0; w(4); scl = 1'b1; w(8); drv = 1'b1; w(8);
  endtask
  task automatic xb(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ak, a);
  endtask
endmodule // serial_host
`default_nettype wire

// file: tb/diag_serial_assertions.sv
// concurrent checks on the management slave pins
`timescale 1ns/10ps
`default_nettype none
module diag_serial_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic tx_off_pin,
  input wire logic laser_fault,
  input wire logic supply_low,
  input wire logic optical_power_low,
  input wire logic tx_disable,
  input wire logic tx_fault,
  input wire logic receive_signal_lost
);
  logic [2:0] cnt;
  logic [4:0] offh;
  // synchronisers still hold reset-era values early on
  wire ok = cnt == 3'h7;
  wire quiet = &{offh, tx_off_pin} || ~|{offh, tx_off_pin};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk) begin
    offh <= {offh[3:0], tx_off_pin};
    cnt <= !resetn ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
  end
  sequence toggle_quiet;
    // a fault seen in the toggle cycle itself would re-arm the latch
    $changed(tx_off_pin) && !laser_fault ##1 (!laser_fault && !supply_low)[*6];
  endsequence
  a_reset_vals: assert property (disable iff (1'b0) !resetn |=> sda_oe_n && tx_disable
    && !tx_fault && !receive_signal_lost) else $error("reset values");
  a_loss_follow: assert property (ok |-> receive_signal_lost == $past(optical_power_low, 3))
    else $error("loss pin");
  a_hw_off: assert property (ok && $past(tx_off_pin, 3) |-> tx_disable)
    else $error("hw off");
  a_supply_fault: assert property (ok && $past(supply_low, 3) |-> tx_fault && tx_disable)
    else $error("supply fault");
  a_fault_set: assert property (ok && $past(laser_fault, 3) |-> tx_fault && tx_disable)
    else $error("laser fault");
  a_fault_latch: assert property (ok && tx_fault && !$past(supply_low, 3) && quiet |=> tx_fault)
    else $error("fault latch");
  a_fault_clear: assert property (ok and toggle_quiet |-> !tx_fault)
    else $error("fault clear");
  a_sda_change: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("data moved");
endmodule // diag_serial_assertions
`default_nettype wire

// file: tb/tb_transceiver_diag_serial_map.sv
// self-checking bench for the transceiver management slave
`timescale 1ns/10ps
`default_nettype none
module tb_transceiver_diag_serial_map;
  logic mclk, resetn, tx_off_pin, laser_fault, supply_low, optical_power_low, id_wr, a;
  logic [7:0] id_wr_addr, id_wr_data, q [16];
  logic [79:0] mons;
  wire logic scl_in, sda_in, sda_oe_n, tx_disable, tx_fault, receive_signal_lost;
  int errors = 0, n_tests = 0;
  always #25 mclk = ~mclk;
  diag_serial dut (
    .mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
    .tx_off_pin(tx_off_pin), .laser_fault(laser_fault), .supply_low(supply_low),
    .optical_power_low(optical_power_low), .tx_disable(tx_disable), .tx_fault(tx_fault),
    .receive_signal_lost(receive_signal_lost),
    .temp_value(mons[79:64]), .vcc_value(mons[63:48]), .bias_value(mons[47:32]),
    .txpwr_value(mons[31:16]), .rxpwr_value(mons[15:0]),
    .id_wr(id_wr), .id_wr_addr(id_wr_addr), .id_wr_data(id_wr_data)
  );
  serial_host h (.mclk(mclk), .sda_oe_n(sda_oe_n), .scl(scl_in), .sda(sda_in));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xk(input logic [7:0] d);
    h.xb(d, 1'b1, q[15], a);
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, input int n);
    h.start(); xk(dev); xk(ofs); h.start(); xk(dev | 8'h01);
    for (int i = 0; i < n; i++) h.xb(8'hFF, i == n - 1, q[i], a);
    h.stop();
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    h.start(); xk(8'hA2); xk(ofs); xk(d); h.stop();
  endtask
  task automatic end_of_test();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    {mclk, resetn, tx_off_pin, laser_fault, supply_low, optical_power_low, id_wr} = 7'h00;
    id_wr_addr = 8'hFF;
    id_wr_data = 8'h3C;
    mons = 80'h1234_5678_9ABC_DEF0_0F1E;
    repeat (6) @(posedge mclk);
    #1;
    chk({4'h0, tx_disable, tx_fault, receive_signal_lost, sda_oe_n}, 8'h09);
    resetn = 1'b1; id_wr = 1'b1;
    h.w(1); id_wr_addr = 8'h00; id_wr_data = 8'hC3;
    h.w(1); id_wr = 1'b0; h.w(4);
    rd(8'hA0, 8'hFF, 2); chk(q[0], 8'h3C); chk(q[1], 8'hC3);
    h.start(); xk(8'hA0); xk(8'h00); xk(8'h11); h.stop(); rd(8'hA0, 8'h00, 1);
    chk(q[0], 8'hC3);
    // second pass with every reading inverted so no monitor bit can stick
    repeat (2) begin
      rd(8'hA2, 8'h60, 10);
      for (int i = 0; i < 10; i++) chk(q[i], mons[79 - 8 * i -: 8]);
      mons = ~mons;
    end
    // unknown device address stays unanswered
    h.start(); h.xb(8'hA4, 1'b1, q[15], a); chk({7'h0, a}, 8'h01); h.stop();
    optical_power_low = 1'b1; tx_off_pin = 1'b1; h.w(6);
    chk({7'h0, receive_signal_lost}, 8'h01); rd(8'hA2, 8'h6E, 1); chk(q[0], 8'h82);
    tx_off_pin = 1'b0; optical_power_low = 1'b0; wr(8'h6E, 8'hFF); rd(8'hA2, 8'h6E, 1);
    chk(q[0], 8'h40); chk({7'h0, tx_disable}, 8'h01);
    wr(8'h6E, 8'h00); h.w(6); chk({7'h0, tx_disable}, 8'h00);
    laser_fault = 1'b1; h.w(6); laser_fault = 1'b0; h.w(6); rd(8'hA2, 8'h6E, 1);
    chk({7'h0, tx_fault}, 8'h01); chk(q[0], 8'h04);
    tx_off_pin = 1'b1; h.w(6); tx_off_pin = 1'b0; h.w(6); chk({7'h0, tx_fault}, 8'h00);
    supply_low = 1'b1; h.w(6); chk({6'h0, tx_fault, tx_disable}, 8'h03);
    supply_low = 1'b0; h.w(6); chk({7'h0, tx_fault}, 8'h00);
    end_of_test();
  end
endmodule // tb_transceiver_diag_serial_map
bind diag_serial diag_serial_assertions chk_i (
  .mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .tx_off_pin(tx_off_pin),
  .laser_fault(laser_fault), .supply_low(supply_low), .optical_power_low(optical_power_low),
  .tx_disable(tx_disable), .tx_fault(tx_fault), .receive_signal_lost(receive_signal_lost)
);
`default_nettype wire
